// ===== bench/ppac_load_model.sv
// Far-side model: a portable device loading one port.
// Assumes drive levels synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module ppac_load_model
	import ppac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic plugged,
	input wire logic overload,
	input wire ppac_drive_s drive,
	output var ppac_sense_s sense
);
	logic [7:0] dis_r;
	// =====================================
	// Comparators
	// Load is only seen while the port is fed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense <= '0;
			dis_r <= 8'h00;
		end else begin
			sense.load_gt_attach <= plugged && (drive.bypass_on || drive.switch_on);
			sense.load_lt_removal <= !plugged;
			sense.over_limit <= overload && drive.switch_on;
			sense.vs_ok <= 1'b1;
			sense.temp_hot <= 1'b0;
			sense.vbus_low <= 1'b0;
			// Slow bleed: bus reads low only after 100 cycles
			dis_r <= drive.discharge_on ? dis_r + {7'h00, dis_r != 8'hff} : 8'h00;
			sense.vbus_dischd <= dis_r > 8'h63;
		end
	end
endmodule : ppac_load_model
`default_nettype wire

// ===== bench/ppac_properties.sv
// Port-level checker for the power attach control.
// Assumes binding onto ppac_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ppac_props
	import ppac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire ppac_sense_s [1:0] port_sense,
	input wire ppac_drive_s [1:0] port_drive,
	input wire logic [1:0] fault_alert_n_out,
	input wire logic [1:0] fault_alert_n_oe_n,
	input wire logic [1:0] attach_flag_n
);
	logic [11:0] held_r;
	// =====================================
	// Attach load hold counter, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			held_r <= 12'h000;
		else if (!port_sense[0].load_gt_attach)
			held_r <= 12'h000;
		else if (held_r != 12'hfff)
			held_r <= held_r + 12'h001;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	excl_sw_a: assert property (!(port_drive[0].bypass_on && port_drive[0].switch_on)
		&& !(port_drive[1].bypass_on && port_drive[1].switch_on)) else $error("both switches closed");
	byp_cap_a: assert property (port_drive[0].bypass_on |-> port_drive[0].bypass_cap
		&& port_drive[0].attach_cap) else $error("bypass without cap");
	disch_open_a: assert property (port_drive[0].discharge_on |-> !port_drive[0].switch_on
		&& !port_drive[0].bypass_on) else $error("switch closed in discharge");
	disch_hold_a: assert property ($rose(port_drive[0].discharge_on)
		|-> port_drive[0].discharge_on[*8]) else $error("discharge too short");
	trip_open_a: assert property (port_drive[0].switch_on && port_sense[0].over_limit
		&& port_drive[0].limit_code > LIM_CC_MAX |=> !port_drive[0].switch_on ##[0:2]
		!fault_alert_n_oe_n[0]) else $error("trip not taken");
	alert_od_a: assert property (fault_alert_n_out == 2'b00
		&& (port_drive[0].bypass_on || port_drive[0].switch_on
		|| port_drive[0].discharge_on || !fault_alert_n_oe_n[0]))
		else $error("alert released in error");
	attach_qual_a: assert property ($fell(attach_flag_n[0])
		|-> held_r >= 12'(ATT_QUAL_CYC))
		else $error("attach too early");
	soft_start_a: assert property ($rose(port_drive[0].switch_on)
		|-> port_drive[0].soft_start) else $error("no soft start");
endmodule : ppac_props
bind ppac_top ppac_props ppac_props_i (.pclk(pclk), .presetn(presetn),
	.port_sense(port_sense), .port_drive(port_drive), .fault_alert_n_out(fault_alert_n_out),
	.fault_alert_n_oe_n(fault_alert_n_oe_n), .attach_flag_n(attach_flag_n));
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench: APB register access plus a load model per port.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import ppac_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, en1 = 1'b0, plug = 1'b0, ovl = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, e;
	logic [3:0] strap = 4'h0;
	ppac_sense_s [1:0] sense;
	ppac_drive_s [1:0] drive;
	logic [1:0] oe_n;
	int n_mismatch = 0, n_compared = 0, r;
	logic [31:0] exp_q[$], msk_q[$];
	logic [11:0] ma_tab [8] = '{12'h212, 12'h3c0, 12'h42e, 12'h500,
		12'h640, 12'h852, 12'ha6e, 12'hc80};
	// =====================================
	// Clock, design and far side
	always #50 pclk = ~pclk;
	ppac_top ppac_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode_limit_strap(strap), .port1_enable_in(en1),
		.port2_enable_in(1'b0), .port_sense(sense), .port_drive(drive),
		.fault_alert_n_out(), .fault_alert_n_oe_n(oe_n), .attach_flag_n());
	for (genvar g = 0; g < 2; g++) begin : g_port
		ppac_load_model ppac_load_model_i (.pclk(pclk), .presetn(presetn),
			.plugged(g == 0 ? plug : 1'b0), .overload(g == 0 ? ovl : 1'b0),
			.drive(drive[g]), .sense(sense[g]));
	end
	task wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One transfer; wait on pready is bounded
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			n_mismatch++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		exp_q.push_back(exp & m);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_cyc
	task do_reset;
		presetn <= 1'b0;
		wait_cyc(10);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : do_reset
	// Read monitor: oldest note against the completing read
	// Every access also checks the error answer against the map
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			chk("slave error", {31'h0, pslverr}, {31'h0, !(paddr inside
				{OFS_CFG, OFS_LIM, OFS_STAT, OFS_STRAP})});
			if (!pwrite)
				chk("read data", prdata & msk_q.pop_front(),
					exp_q.pop_front());
		end
	end
	// =====================================
	// Scenarios
	initial begin
		r = $urandom(32'hea496628);
		// Every strap code, then a late strap change is ignored
		for (int c = 0; c < 16; c++) begin
			strap <= c[3:0];
			do_reset();
			e = {4'h0, ma_tab[c % 8], 10'h000, 1'b1, !c[3], c[3], c[2:0]};
			rd(OFS_STRAP, e, 32'h0fff003f);
			strap <= ~c[3:0];
			rd(OFS_STRAP, e, 32'h0fff003f);
		end
		$display("test strap done");
		strap <= 4'h6;
		do_reset();
		rd(OFS_CFG, 32'h43, 32'hff);
		rd(8'h10, 32'h0, 32'hffffffff);
		// Random requests clamp to the strap limit of 6
		for (int i = 0; i < 4; i++) begin
			r = $urandom % 8;
			apb(1'b1, OFS_LIM, {25'h0, r[2:0], 1'b0, r[2:0]});
			r = (r > 6) ? 6 : r;
			rd(OFS_LIM, {25'h0, r[2:0], 1'b0, r[2:0]}, 32'h77);
		end
		apb(1'b1, OFS_LIM, 32'h77);
		$display("test limit done");
		plug <= 1'b1;
		wait_cyc(2100);
		rd(OFS_STAT, 32'h01, 32'h33);
		apb(1'b1, OFS_CFG, 32'h03);
		wait_cyc(2100);
		rd(OFS_STAT, 32'h00, 32'h33);
		en1 <= 1'b1;
		wait_cyc(4);
		rd(OFS_STAT, 32'h10, 32'h30);
		plug <= 1'b0;
		wait_cyc(3100);
		rd(OFS_STAT, 32'h22, 32'h32);
		wait_cyc(2100);
		rd(OFS_STAT, 32'h00, 32'h30);
		$display("test removal done");
		plug <= 1'b1;
		r = 0;
		while (drive[0].switch_on !== 1'b1 && r < 3000) begin
			@(negedge pclk);
			r++;
		end
		if (drive[0].switch_on !== 1'b1) begin
			n_mismatch++;
			wrap_up();
		end
		chk("soft start", {31'h0, drive[0].soft_start}, 32'h1);
		@(posedge pclk);
		ovl <= 1'b1;
		wait_cyc(4);
		rd(OFS_STAT, 32'h34, 32'h34);
		chk("alert", {31'h0, oe_n[0]}, 32'h0);
		ovl <= 1'b0;
		plug <= 1'b0;
		apb(1'b1, OFS_STAT, 32'h04);
		wait_cyc(2200);
		rd(OFS_STAT, 32'h00, 32'h34);
		chk("alert", {31'h0, oe_n[0]}, 32'h1);
		// Low limit: constant current rides out a short overload
		apb(1'b1, OFS_LIM, 32'h33);
		plug <= 1'b1;
		wait_cyc(2100);
		rd(OFS_STAT, 32'h10, 32'h30);
		chk("cc mode", {31'h0, drive[0].cc_mode}, 32'h1);
		ovl <= 1'b1;
		wait_cyc(300);
		rd(OFS_STAT, 32'h10, 32'h34);
		wait_cyc(300);
		rd(OFS_STAT, 32'h34, 32'h34);
		ovl <= 1'b0;
		plug <= 1'b0;
		$display("test cc done");
		rd(OFS_STAT, 32'h0100, 32'h3700);
		$display("test fault done");
		wait_cyc(2);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire

// ===== verilog/ppac_pkg.sv
// Shared constants and carriers for the dual port power attach control.
// Assumes a 10 MHz pclk; analog comparators arrive as synchronous levels.
package ppac_pkg;
	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned ATT_QUAL_NS = 200000;
	localparam int unsigned REM_QUAL_NS = 300000;
	localparam int unsigned SHORT_RSP_NS = 1500;
	localparam int unsigned OC_PERSIST_NS = 50000;
	localparam int unsigned DISCH_NS = 200000;
	localparam int unsigned RISE_NS = 100000;
	// Least times round up, the response bound rounds down
	localparam int unsigned ATT_QUAL_CYC = (ATT_QUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned REM_QUAL_CYC = (REM_QUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SHORT_RSP_CYC =
		(SHORT_RSP_NS / CLK_NS) > 0 ? SHORT_RSP_NS / CLK_NS : 1;
	localparam int unsigned OC_PERSIST_CYC =
		(OC_PERSIST_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DISCH_CYC = (DISCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RISE_CYC = (RISE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TMR_W = 12;

	// ==========================================================
	// Register map (byte addresses) and fields
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_LIM = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_STRAP = 8'h0c;
	localparam int unsigned CFG_SWEN0 = 0;
	localparam int unsigned CFG_DETDIS = 6;
	localparam int unsigned CFG_PINIGN = 7;
	localparam logic [7:0] CFG_RST = 8'h43;
	localparam logic [7:0] LIM_RST = 8'h77;
	localparam int unsigned LIM_W = 4;
	localparam int unsigned STAT_W = 8;
	localparam int unsigned ST_ATT = 0;
	localparam int unsigned ST_REM = 1;
	localparam int unsigned ST_ERR = 2;
	localparam int unsigned ST_STATE = 4;
	localparam int unsigned STRAP_MA = 16;
	localparam logic [2:0] LIM_CC_MAX = 3'h4;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		PPAC_DETECT,
		PPAC_ACTIVE,
		PPAC_DISCH,
		PPAC_ERROR
	} ppac_state_e;

	typedef struct packed {
		logic load_gt_attach;
		logic load_lt_removal;
		logic over_limit;
		logic vs_ok;
		logic temp_hot;
		logic vbus_low;
		logic vbus_dischd;
	} ppac_sense_s;

	typedef struct packed {
		logic bypass_on;
		logic switch_on;
		logic discharge_on;
		logic soft_start;
		logic cc_mode;
		logic limit_active;
		logic bypass_cap;
		logic attach_cap;
		logic [2:0] limit_code;
	} ppac_drive_s;

	typedef struct packed {
		logic [2:0] hw_limit;
		logic enable_low;
		logic bus_mode;
		logic valid;
	} ppac_strap_s;
endpackage : ppac_pkg

// ===== verilog/ppac_qual.sv
// Qualification timer: one pulse once a condition has held N cycles.
// Assumes cond is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ppac_qual
	import ppac_pkg::*;
#(
	parameter int unsigned N = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic cond,
	output logic hit
);
	localparam logic [TMR_W-1:0] LAST = TMR_W'(N - 1);
	logic [TMR_W-1:0] cnt_r;

	// ==========================================================
	// Count while armed; any dropout restarts the window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (!(run && cond)) begin
			cnt_r <= '0;
		end else if (cnt_r != LAST + 1'b1) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Single pulse so the event is not repeated while held
	assign hit = run && cond && (cnt_r == LAST);
endmodule : ppac_qual
`default_nettype wire

// ===== verilog/ppac_strap.sv
// Power-up strap capture and decode into limit, polarity and mode.
// Assumes the strap pins are stable by the first edge after reset.
`timescale 1ns/1ps
`default_nettype none
module ppac_strap
	import ppac_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] mode_limit_strap,
	output var ppac_strap_s strap,
	output logic [11:0] hw_limit_ma
);
	logic [3:0] code_r;
	logic done_r;

	// ==========================================================
	// Caught once by a clocked edge after release, never by reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			code_r <= 4'h0;
			done_r <= 1'b0;
		end else if (!done_r) begin
			code_r <= mode_limit_strap;
			done_r <= 1'b1;
		end
	end

	// Upper half of the codes flips polarity and drops the bus
	assign strap.hw_limit = code_r[2:0];
	assign strap.enable_low = code_r[3];
	assign strap.bus_mode = !code_r[3];
	assign strap.valid = done_r;

	// Limit in milliamperes, for software reading
	always_comb begin
		unique case (code_r[2:0])
			3'h0: hw_limit_ma = 12'h212;
			3'h1: hw_limit_ma = 12'h3c0;
			3'h2: hw_limit_ma = 12'h42e;
			3'h3: hw_limit_ma = 12'h500;
			3'h4: hw_limit_ma = 12'h640;
			3'h5: hw_limit_ma = 12'h852;
			3'h6: hw_limit_ma = 12'ha6e;
			3'h7: hw_limit_ma = 12'hc80;
		endcase
	end
endmodule : ppac_strap
`default_nettype wire

// ===== verilog/ppac_top.sv
// Dual port power switch control: states, attach/removal, limiting.
// Assumes synchronous comparator inputs per port and an APB master.
//
// Operation
// - Detection off after reset until bit cleared
// - Bypass and port switch never both closed
// - Detect feeds bypass, Active feeds port switch
// - Bypass on: cap current, detection runs
// - Qualified load in Detect sets attach
// - Attach current cap until switch enabled
// - After attach, enable and supply close switch
// - Qualified low load flags removal
// - Removal: open, flag, discharge, back to Detect
// - Switch closed in Active except discharging
// - Strap sampled once after power-up
// - Software limit clamped to strap limit
// - Sixteen codes: eight limits, two polarities
// - Limit fast, persistent overcurrent goes Error
// - Soft start on switch enable
// - Limiting mode applied while switch closed
// - Trip opens switch, Error, fault alert
// - Constant current only at limit up to 1.6A
// - Constant current opens on heat or low VBUS
// - Polarity selects bus or stand-alone mode
// - Alert open drain, released once all clear
`timescale 1ns/1ps
`default_nettype none
module ppac_top
	import ppac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] mode_limit_strap,
	input wire logic port1_enable_in,
	input wire logic port2_enable_in,
	input wire ppac_sense_s [1:0] port_sense,
	output var ppac_drive_s [1:0] port_drive,
	output logic [1:0] fault_alert_n_out,
	output logic [1:0] fault_alert_n_oe_n,
	output logic [1:0] attach_flag_n
);
	// ==========================================================
	// Address decode, shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		return a == OFS_CFG || a == OFS_LIM || a == OFS_STAT ||
			a == OFS_STRAP;
	endfunction

	function automatic logic [2:0] clamp(input logic [2:0] req,
		input logic [2:0] hw);
		return (req > hw) ? hw : req;
	endfunction

	ppac_strap_s strap;
	logic [11:0] hw_limit_ma;
	logic [7:0] cfg_r;
	logic [7:0] lim_r;
	logic [31:0] prdata_r;
	logic wr_en;
	logic rd_setup;
	logic [1:0] pin_en;
	logic [STAT_W-1:0] stat_rd [2];
	logic [2:0] eff_lim [2];
	logic [2*STAT_W-1:0] stat_bus;

	// ==========================================================
	// Shared strap decode
	ppac_strap u_strap (
		.clk(pclk),
		.rst_n(presetn),
		.mode_limit_strap(mode_limit_strap),
		.strap(strap),
		.hw_limit_ma(hw_limit_ma)
	);

	// ==========================================================
	// APB slave: zero wait states, error on unmapped address
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign wr_en = psel && penable && pwrite && mapped(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign prdata = prdata_r;

	// Configuration register; detection starts disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= CFG_RST;
		end else if (wr_en && paddr == OFS_CFG) begin
			cfg_r <= pwdata[7:0];
		end
	end

	// Requested limits; clamped on use so a later strap still caps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_r <= LIM_RST;
		end else if (wr_en && paddr == OFS_LIM) begin
			lim_r <= pwdata[7:0];
		end
	end

	assign stat_bus = {stat_rd[1], stat_rd[0]};

	// Read data latched in setup so it is stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (rd_setup) begin
			unique case (paddr)
				OFS_CFG: prdata_r <= {24'h0, cfg_r};
				OFS_LIM: prdata_r <= {25'h0, eff_lim[1], 1'b0,
					eff_lim[0]};
				OFS_STAT: prdata_r <= {16'h0, stat_bus};
				OFS_STRAP: prdata_r <= {4'h0, hw_limit_ma, 10'h0,
					strap.valid, strap.bus_mode, strap.enable_low,
					strap.hw_limit};
				default: prdata_r <= 32'h0;
			endcase
		end
	end

	// Pins folded to active-high by the strapped polarity
	assign pin_en[0] = port1_enable_in ^ strap.enable_low;
	assign pin_en[1] = port2_enable_in ^ strap.enable_low;

	// ==========================================================
	// Per-port control, one independent copy each
	for (genvar p = 0; p < 2; p++) begin : g_port
		ppac_state_e st_r;
		ppac_state_e st_nxt;
		logic armed_r;
		logic att_r;
		logic rem_r;
		logic err_r;
		logic [TMR_W-1:0] ss_r;
		logic [TMR_W-1:0] tmr_r;
		logic [TMR_W-1:0] oc_r;
		logic en;
		logic en_d_r;
		logic det_en;
		logic att_hit;
		logic rem_hit;
		logic sw_on;
		logic cc_ok;
		logic oc_fast;
		logic oc_trip;
		logic cc_fail;
		logic to_disch;
		logic to_err;
		logic clr_att;
		logic clr_rem;
		logic clr_err;
		ppac_sense_s s;

		assign s = port_sense[p];
		assign det_en = !cfg_r[CFG_DETDIS];
		// Stand-alone ignores software enables entirely
		assign en = strap.valid && (strap.bus_mode ?
			((cfg_r[CFG_PINIGN] || pin_en[p]) && cfg_r[CFG_SWEN0 + p]) :
			pin_en[p]);
		assign eff_lim[p] = strap.bus_mode ?
			clamp(lim_r[p*LIM_W +: 3], strap.hw_limit) :
			strap.hw_limit;

		// Attach only qualifies while parked in Detect
		ppac_qual #(.N(ATT_QUAL_CYC)) u_att (
			.clk(pclk),
			.rst_n(presetn),
			.run(det_en && st_r == PPAC_DETECT && !armed_r),
			.cond(s.load_gt_attach),
			.hit(att_hit)
		);

		// Removal watched in Active and in an armed Detect
		ppac_qual #(.N(REM_QUAL_CYC)) u_rem (
			.clk(pclk),
			.rst_n(presetn),
			.run(det_en && ((st_r == PPAC_DETECT && armed_r) ||
				st_r == PPAC_ACTIVE)),
			.cond(s.load_lt_removal),
			.hit(rem_hit)
		);

		// Switch closed only in Active; discharge is its own state
		assign sw_on = (st_r == PPAC_ACTIVE);
		assign cc_ok = eff_lim[p] <= LIM_CC_MAX;
		assign oc_fast = sw_on && s.over_limit;
		assign oc_trip = oc_fast && !cc_ok;
		// Constant current still gives up if it overheats or sags
		assign cc_fail = sw_on && cc_ok &&
			(s.temp_hot || s.vbus_low ||
			oc_r == TMR_W'(OC_PERSIST_CYC));

		// ==========================================================
		// Next state
		always_comb begin
			st_nxt = st_r;
			unique case (st_r)
				PPAC_DETECT: begin
					if (rem_hit) begin
						st_nxt = PPAC_DISCH;
					end else if (en && s.vs_ok &&
						(!det_en || armed_r || att_hit)) begin
						st_nxt = PPAC_ACTIVE;
					end
				end
				PPAC_ACTIVE: begin
					if (oc_trip || cc_fail) begin
						st_nxt = PPAC_ERROR;
					end else if (rem_hit || (en_d_r && !en) ||
						!s.vs_ok) begin
						st_nxt = PPAC_DISCH;
					end
				end
				PPAC_DISCH: begin
					if (tmr_r == TMR_W'(DISCH_CYC - 1)) begin
						st_nxt = s.vbus_dischd ? PPAC_DETECT :
							PPAC_ERROR;
					end
				end
				PPAC_ERROR: begin
					// Recovery always passes through a discharge
					if (!err_r) begin
						st_nxt = PPAC_DISCH;
					end
				end
			endcase
		end
		assign to_disch = st_nxt == PPAC_DISCH && st_r != PPAC_DISCH;
		assign to_err = st_nxt == PPAC_ERROR && st_r != PPAC_ERROR;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				st_r <= PPAC_DETECT;
			end else begin
				st_r <= st_nxt;
			end
		end

		// Attach memory inside the block; dropped on every discharge
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				armed_r <= 1'b0;
			end else if (to_disch) begin
				armed_r <= 1'b0;
			end else if (att_hit) begin
				armed_r <= 1'b1;
			end
		end

		// Discharge timer
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tmr_r <= '0;
			end else if (st_r != PPAC_DISCH) begin
				tmr_r <= '0;
			end else begin
				tmr_r <= tmr_r + 1'b1;
			end
		end

		// Soft start loaded on every entry to Active
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ss_r <= '0;
			end else if (st_nxt == PPAC_ACTIVE && st_r != PPAC_ACTIVE) begin
				ss_r <= TMR_W'(RISE_CYC);
			end else if (ss_r != '0) begin
				ss_r <= ss_r - 1'b1;
			end
		end

		// Persistence of an overcurrent held under constant current
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				oc_r <= '0;
			end else if (!oc_fast) begin
				oc_r <= '0;
			end else if (oc_r != TMR_W'(OC_PERSIST_CYC)) begin
				oc_r <= oc_r + 1'b1;
			end
		end

		// Enable history; discharge fires on the inactive edge only
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				en_d_r <= 1'b0;
			end else begin
				en_d_r <= en;
			end
		end

		// ==========================================================
		// Sticky status; a set in the clearing cycle wins
		assign clr_att = wr_en && paddr == OFS_STAT &&
			pwdata[p*STAT_W + ST_ATT];
		assign clr_rem = wr_en && paddr == OFS_STAT &&
			pwdata[p*STAT_W + ST_REM];
		assign clr_err = wr_en && paddr == OFS_STAT &&
			pwdata[p*STAT_W + ST_ERR];

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				att_r <= 1'b0;
			end else if (att_hit) begin
				att_r <= 1'b1;
			end else if (clr_att) begin
				att_r <= 1'b0;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rem_r <= 1'b0;
			end else if (rem_hit) begin
				rem_r <= 1'b1;
			end else if (clr_rem) begin
				rem_r <= 1'b0;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				err_r <= 1'b0;
			end else if (to_err) begin
				err_r <= 1'b1;
			end else if (clr_err) begin
				err_r <= 1'b0;
			end
		end

		assign stat_rd[p] = {2'b00, 2'(st_r), 1'b0, err_r, rem_r,
			!att_r};
		assign attach_flag_n[p] = !att_r;

		// ==========================================================
		// Switch drive; bypass gated by the port switch itself
		assign port_drive[p].switch_on = sw_on;
		assign port_drive[p].bypass_on = (st_r == PPAC_DETECT) &&
			!sw_on;
		assign port_drive[p].discharge_on = (st_r == PPAC_DISCH);
		assign port_drive[p].soft_start = sw_on && ss_r != '0;
		assign port_drive[p].cc_mode = sw_on && cc_ok;
		assign port_drive[p].limit_active = oc_fast;
		assign port_drive[p].bypass_cap = (st_r == PPAC_DETECT);
		assign port_drive[p].attach_cap = !sw_on;
		assign port_drive[p].limit_code = eff_lim[p];

		// Open drain: pull low while in error or error flag not cleared
		assign fault_alert_n_out[p] = 1'b0;
		assign fault_alert_n_oe_n[p] = !(err_r ||
			st_r == PPAC_ERROR);
	end
endmodule : ppac_top
`default_nettype wire
